/* logic/pcid_cfg.svh */
// constants for the pulse command input decoder
`ifndef PCID_CFG_SVH
`define PCID_CFG_SVH
`define PCID_FMT_STEP_DIR  4'h0
`define PCID_FMT_FWD_REV   4'h1
`define PCID_FMT_QUAD_X1   4'h2
`define PCID_FMT_QUAD_X2   4'h3
`define PCID_FMT_QUAD_X4   4'h4
`define PCID_FMT_NEG_BASE  4'h5
`define PCID_FMT_MAX       4'h9
`define PCID_TRIG_HIGH     2'h0
`define PCID_TRIG_RISE     2'h1
`define PCID_TRIG_LOW      2'h2
`define PCID_TRIG_FALL     2'h3
`define PCID_ALM_BOTH      2'h0
`define PCID_ALM_NONE      2'h1
`define PCID_ALM_ONLY      2'h2
`define PCID_DEV_RST_VAL   32'h0
`endif

/* logic/pcid_pkg.sv */
// types for the pulse command input decoder
`default_nettype none
package pcid_pkg;
	typedef enum logic [2:0] {
		PCID_STEP_DIR,
		PCID_FWD_REV,
		PCID_QUAD_X1,
		PCID_QUAD_X2,
		PCID_QUAD_X4
	} pcid_fmt_e;
endpackage : pcid_pkg
`default_nettype wire

/* logic/pcid_sync.sv */
// two-flop synchroniser for one pin
`timescale 1ns/1ps
`default_nettype none
module pcid_sync (
	// clock and reset
	input  wire logic mclk,
	input  wire logic rst,
	// pin in, synced out
	input  wire logic pin,
	output var  logic sync
);
	logic meta_q;
	logic meta_d;
	logic sync_q;
	logic sync_d;
	always_comb begin
		meta_d = pin;
		sync_d = meta_q;
	end
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end
	assign sync = sync_q;
endmodule : pcid_sync
`default_nettype wire

/* logic/pcid_top.sv */
// pulse command input decoder with deviation counter clear control
`timescale 1ns/1ps
`default_nettype none
`include "pcid_cfg.svh"
module pcid_top import pcid_pkg::*; #(
	parameter int CNT_W = 32
) (
	// clock and reset
	input  wire logic             mclk,
	input  wire logic             rst,
	// position input settings, captured at start-up
	input  wire logic [3:0]       pulse_format,
	input  wire logic [1:0]       clear_trigger,
	input  wire logic [1:0]       alarm_reset_opt,
	// command pulse pins
	input  wire logic             cmd_a,
	input  wire logic             cmd_b,
	input  wire logic             clr_pin,
	// drive status from same clock
	input  wire logic             alarm,
	input  wire logic             servo_on,
	// position feedback steps, signed, same clock
	input  wire logic signed [1:0] fb_step,
	// outputs
	output var  logic signed [CNT_W-1:0] deviation,
	output var  logic signed [2:0]       cmd_step,
	output var  logic                    dev_cleared
);
	// ---------------------------------------------
	// pin synchronisers
	// ---------------------------------------------
	logic a_s;
	logic b_s;
	logic c_s;
	pcid_sync u_sa (.mclk(mclk), .rst(rst), .pin(cmd_a), .sync(a_s));
	pcid_sync u_sb (.mclk(mclk), .rst(rst), .pin(cmd_b), .sync(b_s));
	pcid_sync u_sc (.mclk(mclk), .rst(rst), .pin(clr_pin), .sync(c_s));

	// ---------------------------------------------
	// settings capture
	// ---------------------------------------------
	// only taken once so a live change cannot glitch the decoder
	logic            cap_q, cap_d;
	pcid_fmt_e       fmt_q, fmt_d;
	logic            neg_q, neg_d;
	logic [1:0]      trig_q, trig_d;
	logic [1:0]      aopt_q, aopt_d;
	always_comb begin
		cap_d  = 1'b1;
		fmt_d  = fmt_q;
		neg_d  = neg_q;
		trig_d = trig_q;
		aopt_d = aopt_q;
		if (!cap_q) begin
			trig_d = clear_trigger;
			aopt_d = alarm_reset_opt;
			neg_d  = (pulse_format >= `PCID_FMT_NEG_BASE) &&
			         (pulse_format <= `PCID_FMT_MAX);
			unique case (neg_d ? pulse_format - `PCID_FMT_NEG_BASE
			                   : pulse_format)
				`PCID_FMT_FWD_REV: fmt_d = PCID_FWD_REV;
				`PCID_FMT_QUAD_X1: fmt_d = PCID_QUAD_X1;
				`PCID_FMT_QUAD_X2: fmt_d = PCID_QUAD_X2;
				`PCID_FMT_QUAD_X4: fmt_d = PCID_QUAD_X4;
				default:           fmt_d = PCID_STEP_DIR;
			endcase
		end
	end
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			cap_q  <= 1'b0;
			fmt_q  <= PCID_STEP_DIR;
			neg_q  <= 1'b0;
			trig_q <= `PCID_TRIG_HIGH;
			aopt_q <= `PCID_ALM_BOTH;
		end else begin
			cap_q  <= cap_d;
			fmt_q  <= fmt_d;
			neg_q  <= neg_d;
			trig_q <= trig_d;
			aopt_q <= aopt_d;
		end
	end

	// ---------------------------------------------
	// warm-up
	// ---------------------------------------------
	// the pin flops and edge history hold reset values, not pin levels,
	// for two edges after capture: waiting stops an idle-high pin
	// from looking like an edge
	logic            warm_q, warm_d;
	logic            live_q, live_d;
	always_comb begin
		warm_d = cap_q;
		live_d = warm_q;
	end
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			warm_q <= 1'b0;
			live_q <= 1'b0;
		end else begin
			warm_q <= warm_d;
			live_q <= live_d;
		end
	end

	// ---------------------------------------------
	// pulse decode
	// ---------------------------------------------
	logic                a_l, b_l;
	logic                pa_q, pa_d, pb_q, pb_d, pc_q, pc_d;
	logic signed [2:0]   step_d, step_q;
	logic                ra, fa, eb;
	assign a_l = a_s ^ neg_q;
	assign b_l = b_s ^ neg_q;
	always_comb begin
		pa_d   = a_l;
		pb_d   = b_l;
		pc_d   = c_s;
		ra     = a_l & ~pa_q;
		fa     = ~a_l & pa_q;
		eb     = b_l ^ pb_q;
		step_d = 3'sh0;
		if (live_q) begin
			unique case (fmt_q)
				PCID_STEP_DIR: if (ra)
					step_d = b_l ? 3'sh1 : -3'sh1;
				PCID_FWD_REV: begin
					if (ra && !(b_l & ~pb_q))
						step_d = 3'sh1;
					else if (!ra && (b_l & ~pb_q))
						step_d = -3'sh1;
				end
				// a leads b counts forward
				PCID_QUAD_X1: if (ra && !b_l)
					step_d = 3'sh1;
				else if (fa && !b_l)
					step_d = -3'sh1;
				PCID_QUAD_X2: if (ra || fa)
					step_d = ((a_l ^ b_l) == 1'b1) ? 3'sh1 : -3'sh1;
				PCID_QUAD_X4: begin
					if ((ra || fa) && !eb)
						step_d = (a_l ^ b_l) ? 3'sh1 : -3'sh1;
					else if (eb && !(ra || fa))
						step_d = (a_l == b_l) ? 3'sh1 : -3'sh1;
				end
			endcase
		end
	end
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			pa_q   <= 1'b0;
			pb_q   <= 1'b0;
			pc_q   <= 1'b0;
			step_q <= 3'sh0;
		end else begin
			pa_q   <= pa_d;
			pb_q   <= pb_d;
			pc_q   <= pc_d;
			step_q <= step_d;
		end
	end

	// ---------------------------------------------
	// deviation counter and clear
	// ---------------------------------------------
	logic                    clr;
	logic                    pin_clr;
	logic                    alm_clr;
	logic signed [CNT_W-1:0] dev_q, dev_d;
	logic                    dc_q, dc_d;
	always_comb begin
		unique case (trig_q)
			`PCID_TRIG_HIGH: pin_clr = c_s;
			`PCID_TRIG_RISE: pin_clr = c_s & ~pc_q;
			`PCID_TRIG_LOW:  pin_clr = ~c_s;
			`PCID_TRIG_FALL: pin_clr = ~c_s & pc_q;
		endcase
		unique case (aopt_q)
			`PCID_ALM_BOTH: alm_clr = alarm | ~servo_on;
			`PCID_ALM_NONE: alm_clr = 1'b0;
			`PCID_ALM_ONLY: alm_clr = alarm;
			default:        alm_clr = 1'b0;
		endcase
		clr   = live_q & (pin_clr | alm_clr);
		dc_d  = clr;
		dev_d = dev_q + CNT_W'(step_q) - CNT_W'(fb_step);
		if (clr)
			dev_d = CNT_W'(`PCID_DEV_RST_VAL);
	end
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			dev_q <= CNT_W'(`PCID_DEV_RST_VAL);
			dc_q  <= 1'b0;
		end else begin
			dev_q <= dev_d;
			dc_q  <= dc_d;
		end
	end
	assign deviation   = dev_q;
	assign cmd_step    = step_q;
	assign dev_cleared = dc_q;

	// ---------------------------------------------
	// assertions
	// ---------------------------------------------
	a_cap_once: assert property (@(posedge mclk) disable iff (rst)
		cap_q |=> $stable(fmt_q) && $stable(trig_q))
		else $error("settings changed after capture");
	a_step_dir: assert property (@(posedge mclk) disable iff (rst)
		(live_q && fmt_q == PCID_STEP_DIR && ra) |=>
		cmd_step == ($past(b_l) ? 3'sh1 : -3'sh1))
		else $error("step/direction count wrong");
	a_fwd_rev: assert property (@(posedge mclk) disable iff (rst)
		(live_q && fmt_q == PCID_FWD_REV && !ra && b_l && !pb_q) |=>
		cmd_step == -3'sh1)
		else $error("reverse pulse not counted");
	a_quad_x1: assert property (@(posedge mclk) disable iff (rst)
		(live_q && fmt_q == PCID_QUAD_X1 && b_l) |=>
		cmd_step == 3'sh0)
		else $error("x1 counted on wrong edge");
	a_quad_x2: assert property (@(posedge mclk) disable iff (rst)
		(live_q && fmt_q == PCID_QUAD_X2 && !ra && !fa) |=>
		cmd_step == 3'sh0)
		else $error("x2 counted without a edge");
	a_quad_x4: assert property (@(posedge mclk) disable iff (rst)
		(live_q && fmt_q == PCID_QUAD_X4 && eb && !ra && !fa) |=>
		cmd_step != 3'sh0)
		else $error("x4 missed b edge");
	a_neg_sense: assert property (@(posedge mclk) disable iff (rst)
		(live_q && neg_q && fmt_q == PCID_STEP_DIR && $past(a_s) && !a_s)
		|=> cmd_step != 3'sh0)
		else $error("active-low step not counted");
	a_pin_clear: assert property (@(posedge mclk) disable iff (rst)
		(live_q && trig_q == `PCID_TRIG_HIGH && c_s) |=>
		deviation == `PCID_DEV_RST_VAL ##0 dev_cleared)
		else $error("level clear missed");
	a_alarm_clr: assert property (@(posedge mclk) disable iff (rst)
		(live_q && (aopt_q == `PCID_ALM_BOTH || aopt_q == `PCID_ALM_ONLY) &&
		 alarm) |=> dev_cleared)
		else $error("alarm clear missed");
	a_keep_opt: assert property (@(posedge mclk) disable iff (rst)
		(cap_q && aopt_q == `PCID_ALM_NONE && !pin_clr) |=>
		!dev_cleared)
		else $error("cleared with keep option");
	a_servo_off: assert property (@(posedge mclk) disable iff (rst)
		(cap_q && aopt_q == `PCID_ALM_ONLY && !alarm && !pin_clr) |=>
		!dev_cleared)
		else $error("cleared on servo off");
	c_fwd: cover property (@(posedge mclk) cmd_step == 3'sh1);
	c_rev: cover property (@(posedge mclk) cmd_step == -3'sh1);
	c_clr: cover property (@(posedge mclk) dev_cleared);
endmodule : pcid_top
`default_nettype wire

/* tb/pcid_host.sv */
// host controller model driving the command pulse pins
`timescale 1ns/1ps
`default_nettype none
module pcid_host (
	// clock and polarity
	input  wire logic mclk,
	input  wire logic inv,
	// command pins
	output wire logic cmd_a,
	output wire logic cmd_b
);
	logic a_q = 1'b0;
	logic b_q = 1'b0;
	// idle pins rest at the inactive level of the polarity
	assign cmd_a = a_q ^ inv;
	assign cmd_b = b_q ^ inv;
	// 4-cycle hold keeps clear of the 3-cycle minimum
	task automatic set(input logic a, input logic b);
		@(posedge mclk);
		a_q <= a;
		b_q <= b;
		repeat (3) @(posedge mclk);
	endtask : set
	task automatic pulse(input logic a, input logic b, input logic d);
		set(a, b | d);
		set(1'b0, d);
	endtask : pulse
	task automatic quad(input logic rev, input int n);
		int k;
		int p;
		for (k = 1; k <= 4 * n; k++) begin
			p = (rev ? -k : k) & 3;
			set(p == 1 || p == 2, p >= 2);
		end
	endtask : quad
endmodule : pcid_host
`default_nettype wire

/* tb/test_pulse_command_input_decoder.sv */
// self-checking bench for the pulse command input decoder
`timescale 1ns/1ps
`default_nettype none
module test_pulse_command_input_decoder;
	logic              mclk = 1'b0;
	logic              rst = 1'b1;
	logic [3:0]        pulse_format = 4'h0;
	logic [1:0]        clear_trigger = 2'h0;
	logic [1:0]        alarm_reset_opt = 2'h1;
	logic              clr_pin = 1'b0;
	logic              alarm = 1'b0;
	logic              servo_on = 1'b1;
	logic signed [1:0] fb_step = 2'sh0;
	int                step_sum = 0;
	logic              inv = 1'b0;
	wire logic         cmd_a;
	wire logic         cmd_b;
	logic signed [31:0] deviation;
	logic signed [2:0] cmd_step;
	logic              dev_cleared;
	int                failures = 0;
	int                check_count = 0;
	always #4 mclk = ~mclk;
	// running total of one-cycle step outputs, zeroed by every restart
	always @(posedge mclk) begin
		if (rst)
			step_sum <= 0;
		else
			step_sum <= step_sum + cmd_step;
	end
	pcid_host host (.mclk(mclk), .inv(inv), .cmd_a(cmd_a), .cmd_b(cmd_b));
	pcid_top dut (
		.mclk(mclk),
		.rst(rst),
		.pulse_format(pulse_format),
		.clear_trigger(clear_trigger),
		.alarm_reset_opt(alarm_reset_opt),
		.cmd_a(cmd_a),
		.cmd_b(cmd_b),
		.clr_pin(clr_pin),
		.alarm(alarm),
		.servo_on(servo_on),
		.fb_step(fb_step),
		.deviation(deviation),
		.cmd_step(cmd_step),
		.dev_cleared(dev_cleared)
	);
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic chk(input logic signed [31:0] seen,
		input logic signed [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH at %0t: saw %0d want %0d", $time, seen, exp);
		end
	endtask : chk
	task automatic start(input logic [3:0] f, input logic [1:0] t,
		input logic [1:0] o);
		@(posedge mclk);
		rst <= 1'b1;
		pulse_format <= f;
		clear_trigger <= t;
		alarm_reset_opt <= o;
		inv <= f > 4'h4;
		repeat (8) @(posedge mclk);
		rst <= 1'b0;
		repeat (3) @(posedge mclk);
		// changed settings must wait for the next restart
		pulse_format <= f ^ 4'h1;
		clear_trigger <= t ^ 2'h2;
		alarm_reset_opt <= o ^ 2'h1;
	endtask : start
	task automatic end_sim;
		$display("checks %0d, mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : end_sim
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_fmt;
		int f;
		int e;
		for (f = 0; f < 10; f++) begin
			start(f[3:0], 2'h0, 2'h1);
			case (f % 5)
			0: begin
				host.set(1'b0, 1'b1);
				repeat (3) host.pulse(1'b1, 1'b0, 1'b1);
				host.set(1'b0, 1'b0);
				repeat (2) host.pulse(1'b1, 1'b0, 1'b0);
			end
			1: begin
				repeat (3) host.pulse(1'b1, 1'b0, 1'b0);
				host.pulse(1'b0, 1'b1, 1'b0);
			end
			default: begin
				host.quad(1'b0, 2);
				host.quad(1'b1, 1);
			end
			endcase
			host.set(1'b0, 1'b0);
			e = f % 5 < 2 ? 1 + f % 5 : 1 << (f % 5 - 2);
			chk(deviation, e);
			chk(step_sum, e);
		end
		$display("test formats done");
	endtask : t_fmt
	task automatic t_trig;
		int t;
		for (t = 0; t < 4; t++) begin
			clr_pin <= t[1];
			start(4'h0, t[1:0], 2'h1);
			host.pulse(1'b1, 1'b0, 1'b1);
			chk(deviation, 1);
			clr_pin <= ~t[1];
			repeat (6) @(posedge mclk);
			chk(deviation, 0);
			// a level mode keeps holding the counter at zero
			host.pulse(1'b1, 1'b0, 1'b1);
			chk(deviation, t[0]);
			clr_pin <= t[1];
			repeat (6) @(posedge mclk);
			host.pulse(1'b1, 1'b0, 1'b1);
			chk(deviation, t[0] ? 2 : 1);
		end
		$display("test clear trigger done");
	endtask : t_trig
	task automatic t_alarm;
		int o;
		int e;
		// the last trigger test leaves the clear pin high
		clr_pin <= 1'b0;
		for (o = 0; o < 4; o++) begin
			start(4'h0, 2'h0, o[1:0]);
			repeat (2) host.pulse(1'b1, 1'b0, 1'b1);
			alarm <= 1'b1;
			repeat (2) @(posedge mclk);
			chk(dev_cleared, !o[0]);
			alarm <= 1'b0;
			e = o[0] ? 2 : 0;
			chk(deviation, e);
			host.pulse(1'b1, 1'b0, 1'b1);
			servo_on <= 1'b0;
			repeat (2) @(posedge mclk);
			servo_on <= 1'b1;
			@(posedge mclk);
			e = (o == 0) ? 0 : e + 1;
			chk(deviation, e);
			// feedback steps count the same counter down
			fb_step <= 2'sh1;
			repeat (2) @(posedge mclk);
			fb_step <= 2'sh0;
			@(posedge mclk);
			chk(deviation, e - 2);
		end
		$display("test alarm options done");
	endtask : t_alarm
	initial begin
		t_fmt();
		t_trig();
		t_alarm();
		end_sim();
	end
	// runs end near 1000 cycles; this allows a wide margin
	initial begin
		#200000;
		failures++;
		end_sim();
	end
endmodule : test_pulse_command_input_decoder
`default_nettype wire
